// ---- core/ssfe_exec.sv ----
`timescale 1ns/100ps
module ssfe_exec
	import ssfe_pkg::*;
#(
	parameter logic [INSTR_W-1:0] SET_CARRY_CODE = OP_SET_CARRY_DFLT,
	parameter int PC_BITS = PC_W
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic instr_valid,
	input wire logic [INSTR_W-1:0] instr,
	input wire logic dm_ext_we,
	input wire logic [DM_ADDR_W-1:0] dm_ext_addr,
	input wire logic [NIB_W-1:0] dm_ext_wdata,
	output logic instr_ready_r,
	output logic [NIB_W-1:0] accumulator_r,
	output ssfe_flags_t flags_r,
	output logic [PC_BITS-1:0] pc_r,
	output logic wdt_slow_sel_r,
	output logic done_r,
	output logic skip_r
);
	// pc arithmetic and the package reset value assume the package width
	if (PC_BITS != PC_W) begin : g_pc_bits_check
		$error("ssfe_exec: PC_BITS must equal PC_W");
	end

	function automatic logic nib_is_zero(input logic [NIB_W-1:0] v);
		return v == '0;
	endfunction

	ssfe_state_t state_r;
	logic [INSTR_W-1:0] instr_q_r;
	logic [NIB_W-1:0] opnd;
	logic accept;
	logic st_exec;
	logic is_shl;
	logic is_shr;
	logic is_skip_if_bit_zero_set;
	logic is_skip_if_bit_one_set;
	logic is_pmf;
	logic is_setcf;
	logic skip_taken;
	logic [NIB_W-1:0] shl_val;
	logic [NIB_W-1:0] shr_val;
	logic [NIB_W-1:0] shift_val;
	logic dm_we;
	logic [DM_ADDR_W-1:0] dm_waddr;
	logic [NIB_W-1:0] dm_wdata;
	logic [DM_ADDR_W-1:0] dm_raddr;
	logic [NIB_W-1:0] rdata_q;

	assign accept = instr_valid && instr_ready_r;
	assign st_exec = state_r == ST_EXEC;
	assign dm_raddr = instr[DM_ADDR_W-1:0]; // RULE_04

	always_comb begin
		is_shl = instr_q_r[INSTR_W-1:OP9_LO] == OP_SHIFT_LEFT;
		is_shr = instr_q_r[INSTR_W-1:OP9_LO] == OP_SHIFT_RIGHT;
		is_skip_if_bit_zero_set = instr_q_r[INSTR_W-1:OP9_LO] == OP_SKIP_BIT0;
		is_skip_if_bit_one_set = instr_q_r[INSTR_W-1:OP9_LO] == OP_SKIP_BIT1;
		is_pmf = instr_q_r[INSTR_W-1:OP8_LO] == OP_WRITE_PMF;
		is_setcf = instr_q_r == SET_CARRY_CODE;
	end

	always_comb begin
		opnd = rdata_q;
		shl_val = {opnd[NIB_W-2:0], 1'b0}; // RULE_05
		shr_val = {1'b0, opnd[NIB_W-1:1]}; // RULE_06
		shift_val = is_shl ? shl_val : shr_val;
		skip_taken = (is_skip_if_bit_zero_set && opnd[0]) || (is_skip_if_bit_one_set && opnd[1]); // RULE_08 RULE_09
	end

	// memory write: exec shift wins, outside writes only while idle
	always_comb begin
		if (st_exec && (is_shl || is_shr)) begin
			dm_we = 1'b1; // RULE_07
			dm_waddr = instr_q_r[DM_ADDR_W-1:0]; // RULE_04
			dm_wdata = shift_val;
		end else begin
			dm_we = dm_ext_we && !st_exec;
			dm_waddr = dm_ext_addr;
			dm_wdata = dm_ext_wdata;
		end
	end

	ssfe_dmem #(
		.ADDR_W(DM_ADDR_W),
		.DATA_W(NIB_W)
	) u_dmem (
		.clk(clk),
		.we(dm_we),
		.waddr(dm_waddr),
		.wdata(dm_wdata),
		.raddr(dm_raddr),
		.rdata_r(rdata_q)
	);

	// machine cycle: take, then execute
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			instr_ready_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					instr_ready_r <= 1'b1;
					if (accept) begin
						state_r <= ST_EXEC;
						instr_ready_r <= 1'b0;
					end
				end
				ST_EXEC: begin
					state_r <= ST_IDLE; // RULE_11
					instr_ready_r <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instr_q_r <= '0;
		end else if (accept) begin
			instr_q_r <= instr;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			accumulator_r <= ACC_RST;
		end else if (st_exec && (is_shl || is_shr)) begin
			accumulator_r <= shift_val; // RULE_07
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags_r <= '0;
		end else if (st_exec) begin
			if (is_setcf) begin
				flags_r.carry_flag <= 1'b1; // RULE_01
			end else if (is_shl) begin
				flags_r.carry_flag <= opnd[NIB_W-1]; // RULE_05
				flags_r.zero_flag <= nib_is_zero(shl_val); // RULE_11
			end else if (is_shr) begin
				flags_r.carry_flag <= opnd[0]; // RULE_06
				flags_r.zero_flag <= nib_is_zero(shr_val); // RULE_11
			end
		end
	end

	// only the watchdog select bit of the immediate is kept
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdt_slow_sel_r <= WDT_SEL_RST;
		end else if (st_exec && is_pmf) begin
			wdt_slow_sel_r <= instr_q_r[PMF_IMM_LO+PMF_WDT_BIT]; // RULE_02 RULE_03
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc_r <= PC_RST;
		end else if (st_exec) begin
			if (skip_taken) begin
				pc_r <= pc_r + PC_BITS'(PC_STEP_SKIP); // RULE_08 RULE_09
			end else begin
				pc_r <= pc_r + PC_BITS'(PC_STEP_NEXT); // RULE_10
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
			skip_r <= 1'b0;
		end else begin
			done_r <= st_exec;
			skip_r <= st_exec && skip_taken;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_take;
		accept;
	endsequence
	sequence s_exec_done;
		st_exec ##1 done_r;
	endsequence

	property p_setcf;
		st_exec && is_setcf |=> flags_r.carry_flag && $stable(flags_r.zero_flag) && $stable(accumulator_r);
	endproperty
	a_setcf: assert property (p_setcf) else $error("set carry failed"); // RULE_01

	property p_pmf_sel;
		st_exec && is_pmf |=> wdt_slow_sel_r == $past(instr_q_r[PMF_IMM_LO+PMF_WDT_BIT]);
	endproperty
	a_pmf_sel: assert property (p_pmf_sel) else $error("watchdog select wrong"); // RULE_02

	property p_pmf_rsv;
		$changed(wdt_slow_sel_r) |-> $past(st_exec && is_pmf);
	endproperty
	a_pmf_rsv: assert property (p_pmf_rsv) else $error("watchdog select changed without write"); // RULE_03

	property p_addr;
		st_exec && (is_shl || is_shr) |=> u_dmem.mem[instr_q_r[DM_ADDR_W-1:0]] == accumulator_r;
	endproperty
	a_addr: assert property (p_addr) else $error("operand address wrong"); // RULE_04

	property p_shl;
		st_exec && is_shl |=> accumulator_r == {$past(opnd[NIB_W-2:0]), 1'b0}
			&& flags_r.carry_flag == $past(opnd[NIB_W-1]);
	endproperty
	a_shl: assert property (p_shl) else $error("shift left wrong"); // RULE_05

	property p_shr;
		st_exec && is_shr |=> accumulator_r == {1'b0, $past(opnd[NIB_W-1:1])} && flags_r.carry_flag == $past(opnd[0]);
	endproperty
	a_shr: assert property (p_shr) else $error("shift right wrong"); // RULE_06

	property p_wb;
		st_exec && (is_shl || is_shr) |-> dm_we ##1 accumulator_r == $past(dm_wdata);
	endproperty
	a_wb: assert property (p_wb) else $error("write back mismatch"); // RULE_07

	property p_skip_if_bit_zero_set;
		st_exec && is_skip_if_bit_zero_set && opnd[0] |=> pc_r == PC_BITS'($past(pc_r) + PC_BITS'(PC_STEP_SKIP)) && skip_r;
	endproperty
	a_skip_if_bit_zero_set: assert property (p_skip_if_bit_zero_set) else $error("bit0 skip missed"); // RULE_08

	property p_skip_if_bit_one_set;
		st_exec && is_skip_if_bit_one_set && opnd[1] |=> pc_r == PC_BITS'($past(pc_r) + PC_BITS'(PC_STEP_SKIP)) && skip_r;
	endproperty
	a_skip_if_bit_one_set: assert property (p_skip_if_bit_one_set) else $error("bit1 skip missed"); // RULE_09

	property p_noskip;
		st_exec && ((is_skip_if_bit_zero_set && !opnd[0]) || (is_skip_if_bit_one_set && !opnd[1]))
			|=> pc_r == PC_BITS'($past(pc_r) + PC_BITS'(PC_STEP_NEXT)) && !skip_r;
	endproperty
	a_noskip: assert property (p_noskip) else $error("false skip"); // RULE_10

	property p_onecycle;
		s_take |=> s_exec_done;
	endproperty
	a_onecycle: assert property (p_onecycle) else $error("instruction not done in one cycle"); // RULE_11

	property p_zero;
		st_exec && (is_shl || is_shr) |=> flags_r.zero_flag == (accumulator_r == '0);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong"); // RULE_11
endmodule // ssfe_exec

// ---- core/ssfe_pkg.sv ----
//Contract
//RULE_01: set-carry forces carry, nothing else changes
//RULE_02: parameter write bit 3 selects slow watchdog
//RULE_03: parameter write bits 0-2 do nothing
//RULE_04: shifts and skips address operand by bits 6:0
//RULE_05: shift left, old bit 3 to carry
//RULE_06: shift right, old bit 0 to carry
//RULE_07: shift result to memory and accumulator, flags
//RULE_08: skip by two when bit 0 set
//RULE_09: skip by two when bit 1 set
//RULE_10: tested bit clear advances counter by one
//RULE_11: one machine cycle; zero flag on zero result
package ssfe_pkg;
	localparam int INSTR_W = 16;
	localparam int PC_W = 11;
	localparam int DM_ADDR_W = 7;
	localparam int NIB_W = 4;
	// opcode fields
	localparam int OP9_LO = 7;
	localparam int OP8_LO = 8;
	localparam logic [8:0] OP_SHIFT_LEFT = 9'h098;
	localparam logic [8:0] OP_SHIFT_RIGHT = 9'h09A;
	localparam logic [8:0] OP_SKIP_BIT0 = 9'h110;
	localparam logic [8:0] OP_SKIP_BIT1 = 9'h111;
	localparam logic [7:0] OP_WRITE_PMF = 8'h16;
	localparam logic [15:0] OP_SET_CARRY_DFLT = 16'h0D00;
	// parameter flag immediate: bits 7:4, watchdog select is immediate bit 3
	localparam int PMF_IMM_LO = 4;
	localparam int PMF_WDT_BIT = 3;
	// program counter steps
	localparam int PC_STEP_NEXT = 1;
	localparam int PC_STEP_SKIP = 2;
	// reset values
	localparam logic [PC_W-1:0] PC_RST = 11'h000;
	localparam logic [NIB_W-1:0] ACC_RST = 4'h0;
	localparam logic WDT_SEL_RST = 1'b0;

	typedef struct packed {
		logic carry_flag;
		logic zero_flag;
	} ssfe_flags_t;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_EXEC
	} ssfe_state_t;
endpackage

// ---- core/ssfe_dmem.sv ----
`timescale 1ns/100ps
module ssfe_dmem
	import ssfe_pkg::*;
#(
	parameter int ADDR_W = DM_ADDR_W,
	parameter int DATA_W = NIB_W
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [ADDR_W-1:0] raddr,
	output logic [DATA_W-1:0] rdata_r
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// the array needs at least one address bit and one data bit
	if (ADDR_W < 1 || DATA_W < 1) begin : g_param_check
		$error("ssfe_dmem: ADDR_W and DATA_W must be at least 1");
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_r <= mem[raddr];
	end
endmodule // ssfe_dmem

// ---- verification/tb_shift_skip_flag_exec.sv ----
`timescale 1ns/100ps
module tb_shift_skip_flag_exec
	import ssfe_pkg::*;
;
	logic clk;
	logic rst;
	logic instr_valid;
	logic [INSTR_W-1:0] instr;
	logic dm_ext_we;
	logic [DM_ADDR_W-1:0] dm_ext_addr;
	logic [NIB_W-1:0] dm_ext_wdata;
	logic instr_ready_r;
	logic [NIB_W-1:0] accumulator_r;
	ssfe_flags_t flags_r;
	logic [PC_W-1:0] pc_r;
	logic wdt_slow_sel_r;
	logic done_r;
	logic skip_r;
	logic [PC_W-1:0] exp_pc;
	int failures;
	int num_checks;

	ssfe_exec ssfe_exec_i (
		.clk(clk),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr(instr),
		.dm_ext_we(dm_ext_we),
		.dm_ext_addr(dm_ext_addr),
		.dm_ext_wdata(dm_ext_wdata),
		.instr_ready_r(instr_ready_r),
		.accumulator_r(accumulator_r),
		.flags_r(flags_r),
		.pc_r(pc_r),
		.wdt_slow_sel_r(wdt_slow_sel_r),
		.done_r(done_r),
		.skip_r(skip_r)
	);

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic mem_write(input logic [6:0] a, input logic [3:0] d);
		@(posedge clk);
		dm_ext_we <= 1'b1;
		dm_ext_addr <= a;
		dm_ext_wdata <= d;
		@(posedge clk);
		dm_ext_we <= 1'b0;
	endtask

	// offers one word, waits for completion, judges pc, skip, accumulator and flags
	task automatic exec(input logic [15:0] w, input int step, input logic [3:0] acc, input logic c, input logic z);
		int n;
		n = 0;
		@(negedge clk);
		while (instr_ready_r !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		instr_valid <= 1'b1;
		instr <= w;
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
		while (done_r !== 1'b1 && n < 8) begin
			@(negedge clk);
			n++;
		end
		if (n >= 8) begin
			failures++;
			report_and_stop();
		end
		exp_pc = exp_pc + PC_W'(step);
		check("pc", exp_pc, pc_r);
		check("skip", step == 2, skip_r);
		check("accumulator", acc, accumulator_r);
		check("carry", c, flags_r.carry_flag);
		check("zero", z, flags_r.zero_flag);
		@(negedge clk);
		check("done pulse", 1'b0, done_r);
	endtask

	task automatic t_reset();
		check("pc", PC_RST, pc_r);
		check("accumulator", ACC_RST, accumulator_r);
		check("flags", 2'b00, flags_r);
		check("wdt select", WDT_SEL_RST, wdt_slow_sel_r);
		check("done", 1'b0, done_r);
		check("skip", 1'b0, skip_r);
		check("ready", 1'b0, instr_ready_r);
	endtask

	task automatic t_shift_left();
		mem_write(7'h05, 4'h9);
		mem_write(7'h45, 4'h8);
		exec({OP_SHIFT_LEFT, 7'h05}, 1, 4'h2, 1'b1, 1'b0);
		exec({OP_SHIFT_LEFT, 7'h05}, 1, 4'h4, 1'b0, 1'b0);
		exec({OP_SHIFT_LEFT, 7'h45}, 1, 4'h0, 1'b1, 1'b1);
	endtask

	task automatic t_set_carry();
		exec({OP_SHIFT_LEFT, 7'h05}, 1, 4'h8, 1'b0, 1'b0);
		exec(OP_SET_CARRY_DFLT, 1, 4'h8, 1'b1, 1'b0);
	endtask

	task automatic t_shift_right();
		mem_write(7'h7F, 4'h6);
		exec({OP_SHIFT_RIGHT, 7'h7F}, 1, 4'h3, 1'b0, 1'b0);
		exec({OP_SHIFT_RIGHT, 7'h7F}, 1, 4'h1, 1'b1, 1'b0);
		exec({OP_SHIFT_RIGHT, 7'h7F}, 1, 4'h0, 1'b1, 1'b1);
	endtask

	task automatic t_skip();
		mem_write(7'h10, 4'h1);
		mem_write(7'h11, 4'h2);
		exec({OP_SKIP_BIT0, 7'h10}, 2, 4'h0, 1'b1, 1'b1);
		exec({OP_SKIP_BIT1, 7'h10}, 1, 4'h0, 1'b1, 1'b1);
		exec({OP_SKIP_BIT0, 7'h11}, 1, 4'h0, 1'b1, 1'b1);
		exec({OP_SKIP_BIT1, 7'h11}, 2, 4'h0, 1'b1, 1'b1);
	endtask

	task automatic t_param();
		exec({OP_WRITE_PMF, 4'h7, 4'h0}, 1, 4'h0, 1'b1, 1'b1);
		check("wdt select", 1'b0, wdt_slow_sel_r);
		exec({OP_WRITE_PMF, 4'h8, 4'h0}, 1, 4'h0, 1'b1, 1'b1);
		check("wdt select", 1'b1, wdt_slow_sel_r);
		exec({OP_WRITE_PMF, 4'hF, 4'hF}, 1, 4'h0, 1'b1, 1'b1);
		check("wdt select", 1'b1, wdt_slow_sel_r);
		exec({OP_WRITE_PMF, 4'h0, 4'h0}, 1, 4'h0, 1'b1, 1'b1);
		check("wdt select", 1'b0, wdt_slow_sel_r);
	endtask

	initial begin
		failures = 0;
		num_checks = 0;
		exp_pc = PC_RST;
		rst = 1'b1;
		instr_valid = 1'b0;
		instr = 16'h0000;
		dm_ext_we = 1'b0;
		dm_ext_addr = 7'h00;
		dm_ext_wdata = 4'h0;
		repeat (7) @(posedge clk);
		@(negedge clk);
		t_reset();
		@(posedge clk);
		rst <= 1'b0;
		t_shift_left();
		t_set_carry();
		t_shift_right();
		t_skip();
		t_param();
		report_and_stop();
	end
endmodule // tb_shift_skip_flag_exec
